/* File: include/analog_output_param_diag_pkg.sv */
package analog_output_param_diag_pkg;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] record_number;
        logic [4:0] byte_index;
        logic [7:0] wr_data;
    } record_req_type;

    typedef struct packed {
        logic       valid;
        logic       error;
        logic [7:0] data;
    } record_resp_type;

    typedef enum logic [1:0] {
        RANGE_FMTA_KIND,
        RANGE_FMTB_KIND,
        RANGE_OFF_KIND,
        RANGE_BAD_KIND
    } range_kind_type;

endpackage

/* File: include/analog_output_param_diag_regs.svh */
`ifndef ANALOG_OUTPUT_PARAM_DIAG_REGS_SVH
`define ANALOG_OUTPUT_PARAM_DIAG_REGS_SVH

// Record numbers
`define REC_PARAM_BASE      8'h00
`define REC_DIAG_SHORT      8'h00
`define REC_DIAG_FULL       8'h01
`define REC_RANGE_CH0       8'h80
`define REC_RANGE_CH3       8'h83

// Byte positions inside the records
`define PAR_SPARE_IDX       5'h00
`define PAR_SHORT_EN_IDX    5'h01
`define DIAG_SHORT_LEN      5'h04
`define DIAG_FULL_LEN       5'h14
`define DIAG_SUMMARY_IDX    5'h00
`define DIAG_CLASS_IDX      5'h01
`define DIAG_SPARE_IDX      5'h02
`define DIAG_INTERNAL_IDX   5'h03
`define DIAG_KIND_IDX       5'h04
`define DIAG_BITS_IDX       5'h05
`define DIAG_COUNT_IDX      5'h06
`define DIAG_GROUP_IDX      5'h07
`define DIAG_CHAN0_IDX      5'h08
`define DIAG_STAMP_IDX      5'h10

// Reset and constant values
`define SHORT_EN_RESET      8'h00
`define SHORT_EN_MASK       8'h0F
`define RANGE_RESET         8'h10
`define RANGE_FMTA          8'h10
`define RANGE_FMTB          8'h20
`define RANGE_OFF           8'hFF
`define CLASS_INFO_VALUE    8'h15
`define CHANNEL_KIND_VALUE  8'h73
`define DIAG_BITS_VALUE     8'h08
`define CHANNEL_COUNT_VALUE 8'h04

// Field positions
`define SUM_MODULE_BIT      0
`define SUM_INTERNAL_BIT    1
`define SUM_EXTERNAL_BIT    2
`define SUM_CHANNEL_BIT     3
`define SUM_AUX_BIT         4
`define SUM_PARAM_BIT       7
`define INT_OVERFLOW_BIT    3
`define INT_COMM_BIT        4
`define CHF_PARAM_BIT       0
`define CHF_SHORT_BIT       3

// Scaling: millivolt output = code * gain >> 16
`define FMTA_MAX_CODE       16'd32511
`define FMTB_MAX_CODE       16'd20480
`define FMTA_GAIN_MV        16'd23704
`define FMTB_GAIN_MV        17'd40000

// Microsecond ticker
`define TICK_PERIOD_NS      8
`define TICK_US_NS          1000
`define TICK_CYCLES         (`TICK_US_NS / `TICK_PERIOD_NS)

`endif

/* File: tb/analog_output_param_diag_tb.sv */
`include "analog_output_param_diag_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module analog_output_param_diag_tb;
    import analog_output_param_diag_pkg::*;

    typedef struct packed {
        logic [7:0] rec;
        logic [4:0] idx;
        logic [7:0] data;
        logic       err;
    } row_type;

    logic            ref_clk = 1'b0;
    logic            sys_rst = 1'b1;
    logic            clk_en = 1'b1;
    record_req_type  req;
    record_resp_type resp_q;
    logic [63:0]     ao_codes = {16'h0000, 16'h0000, 16'h0000, 16'h6C00};
    logic [3:0]      short_sense = 4'h0;
    logic            aux_supply_ok = 1'b1;
    logic            diag_overflow = 1'b0;
    logic            comm_error = 1'b0;
    logic [63:0]     dac_mv_q;
    logic [3:0]      chan_active_q;
    logic [3:0]      chan_err_led_q;
    logic            group_err_led_q;
    int              fail_count = 0;
    int              compares = 0;
    int              cyc = 0;
    int              rel_cyc = 0;
    logic [7:0]      rng [4] = '{8'h10, 8'h10, 8'h10, 8'h10};
    logic [7:0]      d;
    logic            e;
    logic [31:0]     ts;
    int              us;
    row_type         rows [31] = '{
        '{8'h01, 5'h00, 8'h00, 1'b0}, '{8'h01, 5'h01, 8'h15, 1'b0}, '{8'h01, 5'h02, 8'h00, 1'b0},
        '{8'h01, 5'h03, 8'h00, 1'b0}, '{8'h01, 5'h04, 8'h73, 1'b0}, '{8'h01, 5'h05, 8'h08, 1'b0},
        '{8'h01, 5'h06, 8'h04, 1'b0}, '{8'h01, 5'h07, 8'h00, 1'b0}, '{8'h01, 5'h08, 8'h00, 1'b0},
        '{8'h01, 5'h09, 8'h00, 1'b0}, '{8'h01, 5'h0A, 8'h00, 1'b0}, '{8'h01, 5'h0B, 8'h00, 1'b0},
        '{8'h01, 5'h0C, 8'h00, 1'b0}, '{8'h01, 5'h0D, 8'h00, 1'b0}, '{8'h01, 5'h0E, 8'h00, 1'b0},
        '{8'h01, 5'h0F, 8'h00, 1'b0}, '{8'h01, 5'h10, 8'h00, 1'b0}, '{8'h01, 5'h11, 8'h00, 1'b0},
        '{8'h01, 5'h12, 8'h00, 1'b0}, '{8'h01, 5'h13, 8'h00, 1'b0}, '{8'h00, 5'h00, 8'h00, 1'b0},
        '{8'h00, 5'h01, 8'h15, 1'b0}, '{8'h00, 5'h02, 8'h00, 1'b0}, '{8'h00, 5'h03, 8'h00, 1'b0},
        '{8'h80, 5'h00, 8'h10, 1'b0}, '{8'h81, 5'h00, 8'h10, 1'b0}, '{8'h82, 5'h00, 8'h10, 1'b0},
        '{8'h83, 5'h00, 8'h10, 1'b0}, '{8'h00, 5'h04, 8'h00, 1'b1}, '{8'h01, 5'h14, 8'h00, 1'b1},
        '{8'h02, 5'h00, 8'h00, 1'b1}};

    always #4 ref_clk = ~ref_clk;

    analog_output_param_diag u_dut (
        .ref_clk         (ref_clk),
        .sys_rst         (sys_rst),
        .clk_en          (clk_en),
        .req             (req),
        .resp_q          (resp_q),
        .ao_codes        (ao_codes),
        .short_sense     (short_sense),
        .aux_supply_ok   (aux_supply_ok),
        .diag_overflow   (diag_overflow),
        .comm_error      (comm_error),
        .dac_mv_q        (dac_mv_q),
        .chan_active_q   (chan_active_q),
        .chan_err_led_q  (chan_err_led_q),
        .group_err_led_q (group_err_led_q)
    );

    record_host_model u_host (
        .ref_clk (ref_clk),
        .req     (req),
        .resp_q  (resp_q)
    );

    task automatic stop_test();
        if (fail_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Bound well above the few hundred cycles the sequence needs
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 8000) begin
            fail_count++;
            stop_test();
        end
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    task automatic rd(input logic [7:0] rec, input logic [4:0] idx, output logic [7:0] data, output logic err);
        logic vld;
        u_host.read_rec(rec, idx, data, err, vld);
        check(64'(vld), 64'h1, "read answer");
    endtask

    // Clamp to zero and to the overrange ceiling, then scale
    function automatic logic [15:0] exp_mv(input logic [15:0] code, input logic [7:0] r);
        logic [31:0] c;
        c = code[15] ? 32'h0 : {16'h0, code};
        if (r == 8'h10) begin
            return 16'((((c > 32'h7EFF) ? 32'h7EFF : c) * `FMTA_GAIN_MV) >> 16);
        end
        if (r == 8'h20) begin
            return 16'((((c > 32'h5000) ? 32'h5000 : c) * `FMTB_GAIN_MV) >> 16);
        end
        return 16'h0000;
    endfunction

    task automatic check_outputs();
        repeat (3) @(posedge ref_clk);
        #1;
        for (int n = 0; n < 4; n++) begin
            check(64'(dac_mv_q[16*n +: 16]), 64'(exp_mv(ao_codes[16*n +: 16], rng[n])), "mv");
            check(64'(chan_active_q[n]), 64'(rng[n] == 8'h10 || rng[n] == 8'h20), "active");
        end
    endtask

    initial begin
        repeat (16) @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        rel_cyc = cyc;
        check_outputs();
        for (int i = 0; i < 31; i++) begin
            rd(rows[i].rec, rows[i].idx, d, e);
            check(64'({d, e}), 64'({rows[i].data, rows[i].err}), "row");
        end
        ao_codes = {16'h8000, 16'h03E8, 16'h4000, 16'h7FFF};
        u_host.write_rec(8'h81, 5'h00, 8'h20);
        rng[1] = 8'h20;
        check_outputs();
        ao_codes[31:16] = 16'h7530;
        u_host.write_rec(8'h82, 5'h00, 8'hFF);
        rng[2] = 8'hFF;
        check_outputs();
        repeat (400) @(posedge ref_clk);
        u_host.write_rec(8'h83, 5'h00, 8'h33);
        us = (cyc - rel_cyc) / 125;
        rng[3] = 8'h33;
        check_outputs();
        check(64'(chan_err_led_q[3]), 64'h1, "led");
        rd(8'h01, 5'h00, d, e);
        check(64'(d & 8'h80), 64'h80, "summary param");
        rd(8'h01, 5'h0B, d, e);
        check(64'(d), 64'h01, "chan fault");
        rd(8'h01, 5'h07, d, e);
        check(64'(d), 64'h08, "group");
        for (int b = 0; b < 4; b++) begin
            rd(8'h01, 5'(16 + b), d, e);
            ts[8*b +: 8] = d;
        end
        check(64'(ts >= 32'(us - 1) && ts <= 32'(us + 1)), 64'h1, "stamp");
        u_host.write_rec(8'h83, 5'h00, 8'h10);
        rng[3] = 8'h10;
        u_host.write_rec(8'h00, 5'h01, 8'hF1);
        short_sense = 4'h3;
        repeat (6) @(posedge ref_clk);
        #1;
        check(64'(chan_err_led_q[1:0]), 64'h1, "short led");
        check(64'(group_err_led_q), 64'h1, "group led");
        rd(8'h01, 5'h08, d, e);
        check(64'(d), 64'h08, "short ch0");
        rd(8'h01, 5'h09, d, e);
        check(64'(d), 64'h00, "short ch1");
        rd(8'h01, 5'h07, d, e);
        check(64'(d), 64'h01, "group short");
        diag_overflow = 1'b1;
        comm_error = 1'b1;
        aux_supply_ok = 1'b0;
        repeat (6) @(posedge ref_clk);
        rd(8'h00, 5'h03, d, e);
        check(64'(d), 64'h18, "internal");
        rd(8'h00, 5'h00, d, e);
        check(64'(d & 8'h10), 64'h10, "aux");
        diag_overflow = 1'b0;
        comm_error = 1'b0;
        aux_supply_ok = 1'b1;
        short_sense = 4'h1;
        ao_codes[15:0] = 16'h8000;
        u_host.write_rec(8'h80, 5'h00, 8'h20);
        rng[0] = 8'h20;
        check_outputs();
        @(posedge ref_clk);
        #1;
        sys_rst = 1'b1;
        @(posedge ref_clk);
        #1;
        sys_rst = 1'b0;
        repeat (6) @(posedge ref_clk);
        rd(8'h80, 5'h00, d, e);
        check(64'(d), 64'h10, "range reset");
        rd(8'h01, 5'h08, d, e);
        check(64'(d), 64'h00, "enable reset");
        // Frozen clock enable must drop the write
        clk_en = 1'b0;
        u_host.write_rec(8'h81, 5'h00, 8'hFF);
        clk_en = 1'b1;
        rd(8'h81, 5'h00, d, e);
        check(64'(d), 64'h10, "frozen write");
        stop_test();
    end
endmodule

`default_nettype wire

/* File: tb/record_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

module record_host_model (
    input  wire logic                                          ref_clk,
    output var  analog_output_param_diag_pkg::record_req_type  req,
    input  wire analog_output_param_diag_pkg::record_resp_type resp_q
);
    import analog_output_param_diag_pkg::*;

    initial begin
        req = '0;
    end

    // Released lines toggle so a stale address never looks like a live one
    task automatic release_bus();
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.record_number = ~req.record_number;
        req.byte_index = ~req.byte_index;
        req.wr_data = ~req.wr_data;
    endtask

    // Spare, short enable on rec 00h, ranges on rec 80h..83h
    task automatic write_rec(input logic [7:0] rec, input logic [4:0] idx, input logic [7:0] data);
        @(posedge ref_clk);
        #1;
        req.wr = 1'b1;
        req.record_number = rec;
        req.byte_index = idx;
        req.wr_data = data;
        @(posedge ref_clk);
        #1;
        release_bus();
    endtask

    // Answer lands on the same edge that takes the strobe
    task automatic read_rec(input logic [7:0] rec, input logic [4:0] idx,
                            output logic [7:0] data, output logic err, output logic vld);
        @(posedge ref_clk);
        #1;
        req.rd = 1'b1;
        req.record_number = rec;
        req.byte_index = idx;
        @(posedge ref_clk);
        #1;
        vld = resp_q.valid;
        data = resp_q.data;
        err = resp_q.error;
        release_bus();
    endtask
endmodule

`default_nettype wire

/* File: verilog/analog_output_param_diag.sv */
// Function
// - Range select resets to 10h; FFh switches that channel off.
// - Short detect enable bits 0..3 per channel, upper bits reserved, reset 00h.
// - Code 10h: 27648 is 10 V, overrange to 32511, negatives clamp to 0 V.
// - Code 20h: 16384 is 10 V, overrange to 20480, negatives clamp to 0 V.
// - Parameter record 00h: spare, short enable; range bytes for channels 0..3 on records 80h..83h.
// - Errors light channel indicator and enter diagnostics; no interrupt raised.
// - Full diagnostic block on record 01h; first four bytes on record 00h.
// - Summary byte: failure, internal, external, channel, aux missing, parameter error.
// - Module class byte reads 15h: analog class, channel info present.
// - Internal byte: bit 3 buffer overflow, bit 4 communication error.
// - Channel kind byte reads 73h, analog output, bit 7 reserved.
// - Count bytes report 08h bits per channel and 04h channels.
// - Group error byte bit n set when channel n has an error.
// - Channel fault byte: bit 0 parameter error, bit 3 short to ground.
// - Short faults reported only where detection is enabled.
// - Four reserved zero bytes follow channel faults, then 4-byte timestamp.
// - Microsecond ticker starts at zero and wraps after 32-bit maximum.
`include "analog_output_param_diag_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module analog_output_param_diag (
    input  wire logic                                    ref_clk,
    input  wire logic                                    sys_rst,
    input  wire logic                                    clk_en,
    input  wire analog_output_param_diag_pkg::record_req_type req,
    output var  analog_output_param_diag_pkg::record_resp_type resp_q,
    input  wire logic [63:0]                             ao_codes,
    input  wire logic [3:0]                              short_sense,
    input  wire logic                                    aux_supply_ok,
    input  wire logic                                    diag_overflow,
    input  wire logic                                    comm_error,
    output logic [63:0]                                  dac_mv_q,
    output logic [3:0]                                   chan_active_q,
    output logic [3:0]                                   chan_err_led_q,
    output logic                                         group_err_led_q
);
    import analog_output_param_diag_pkg::*;

    logic [7:0]  short_en_q;
    logic [31:0] range_sel_q;
    logic [3:0]  short_meta_q;
    logic [3:0]  short_sync_q;
    logic        aux_meta_q;
    logic        aux_sync_q;
    logic [6:0]  tick_div_q;
    logic [31:0] us_ticker_q;
    logic [31:0] stamp_q;
    logic [7:0]  summary_d;
    logic [7:0]  summary_q;
    logic [7:0]  internal_d;
    logic [7:0]  group_d;
    logic [31:0] chan_fault_d;
    logic [31:0] chan_fault_q;
    logic [3:0]  param_err;
    logic [7:0]  diag_byte;
    logic        diag_event;

    // Short sense and aux supply pins cross in through two flops
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            short_meta_q <= 4'h0;
            short_sync_q <= 4'h0;
            aux_meta_q   <= 1'b1;
            aux_sync_q   <= 1'b1;
        end else if (clk_en) begin
            short_meta_q <= short_sense;
            short_sync_q <= short_meta_q;
            aux_meta_q   <= aux_supply_ok;
            aux_sync_q   <= aux_meta_q;
        end
    end

    // Parameter writes
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            short_en_q  <= `SHORT_EN_RESET;
            range_sel_q <= {4{`RANGE_RESET}};
        end else if (clk_en && req.wr) begin
            if (req.record_number == `REC_PARAM_BASE && req.byte_index == `PAR_SHORT_EN_IDX) begin
                short_en_q <= req.wr_data & `SHORT_EN_MASK;
            end
            if (req.record_number >= `REC_RANGE_CH0 && req.record_number <= `REC_RANGE_CH3
                && req.byte_index == 5'h00) begin
                range_sel_q[8*req.record_number[1:0] +: 8] <= req.wr_data;
            end
        end
    end

    // Free-running microsecond ticker
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            tick_div_q  <= 7'h00;
            us_ticker_q <= 32'h0000_0000;
        end else if (clk_en) begin
            if (tick_div_q == 7'(`TICK_CYCLES - 1)) begin
                tick_div_q  <= 7'h00;
                us_ticker_q <= us_ticker_q + 32'h0000_0001;
            end else begin
                tick_div_q <= tick_div_q + 7'h01;
            end
        end
    end

    // Per-channel range decode, scaling and faults
    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            range_kind_type kind;
            logic [15:0]    code;
            logic [15:0]    clamped;
            logic [32:0]    product;
            always_comb begin
                code = ao_codes[16*ch +: 16];
                case (range_sel_q[8*ch +: 8])
                    `RANGE_FMTA: kind = RANGE_FMTA_KIND;
                    `RANGE_FMTB: kind = RANGE_FMTB_KIND;
                    `RANGE_OFF: kind = RANGE_OFF_KIND;
                    default: kind = RANGE_BAD_KIND;
                endcase
                clamped = 16'h0000;
                product = 33'h0_0000_0000;
                if (kind == RANGE_FMTA_KIND) begin
                    clamped = code[15] ? 16'h0000 :
                              (code > `FMTA_MAX_CODE ? `FMTA_MAX_CODE : code);
                    product = {17'h0_0000, clamped} * {17'h0_0000, `FMTA_GAIN_MV};
                end else if (kind == RANGE_FMTB_KIND) begin
                    clamped = code[15] ? 16'h0000 :
                              (code > `FMTB_MAX_CODE ? `FMTB_MAX_CODE : code);
                    product = {17'h0_0000, clamped} * {16'h0000, `FMTB_GAIN_MV};
                end
            end
            assign param_err[ch] = (kind == RANGE_BAD_KIND);
            always_comb begin
                chan_fault_d[8*ch +: 8] = 8'h00;
                chan_fault_d[8*ch + `CHF_PARAM_BIT] = param_err[ch];
                chan_fault_d[8*ch + `CHF_SHORT_BIT] = short_sync_q[ch] && short_en_q[ch];
                group_d[ch] = |chan_fault_d[8*ch +: 8];
            end
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    dac_mv_q[16*ch +: 16] <= 16'h0000;
                    chan_active_q[ch]     <= 1'b0;
                end else if (clk_en) begin
                    dac_mv_q[16*ch +: 16] <= product[31:16];
                    chan_active_q[ch]     <= (kind == RANGE_FMTA_KIND) || (kind == RANGE_FMTB_KIND);
                end
            end
        end
    endgenerate

    assign group_d[7:4] = 4'h0;

    always_comb begin
        internal_d = 8'h00;
        internal_d[`INT_OVERFLOW_BIT] = diag_overflow;
        internal_d[`INT_COMM_BIT]     = comm_error;
        summary_d = 8'h00;
        summary_d[`SUM_INTERNAL_BIT] = |internal_d;
        summary_d[`SUM_AUX_BIT]      = !aux_sync_q;
        summary_d[`SUM_EXTERNAL_BIT] = !aux_sync_q || |(short_sync_q & short_en_q[3:0]);
        summary_d[`SUM_CHANNEL_BIT]  = |group_d;
        summary_d[`SUM_PARAM_BIT]    = |param_err;
        summary_d[`SUM_MODULE_BIT]   = |internal_d || |group_d || !aux_sync_q;
    end

    // A newly set summary or channel fault bit stamps the ticker
    assign diag_event = |(summary_d & ~summary_q) || |(chan_fault_d & ~chan_fault_q);

    // Diagnostics and indicators; no interrupt path exists
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            summary_q       <= 8'h00;
            chan_fault_q    <= 32'h0000_0000;
            stamp_q         <= 32'h0000_0000;
            chan_err_led_q  <= 4'h0;
            group_err_led_q <= 1'b0;
        end else if (clk_en) begin
            summary_q       <= summary_d;
            chan_fault_q    <= chan_fault_d;
            chan_err_led_q  <= group_d[3:0];
            group_err_led_q <= summary_d[`SUM_MODULE_BIT];
            if (diag_event) begin
                stamp_q <= us_ticker_q;
            end
        end
    end

    // Diagnostic block byte map
    always_comb begin
        case (req.byte_index)
            `DIAG_SUMMARY_IDX: diag_byte = summary_q;
            `DIAG_CLASS_IDX: diag_byte = `CLASS_INFO_VALUE;
            `DIAG_SPARE_IDX: diag_byte = 8'h00;
            `DIAG_INTERNAL_IDX: diag_byte = internal_d;
            `DIAG_KIND_IDX: diag_byte = `CHANNEL_KIND_VALUE;
            `DIAG_BITS_IDX: diag_byte = `DIAG_BITS_VALUE;
            `DIAG_COUNT_IDX: diag_byte = `CHANNEL_COUNT_VALUE;
            `DIAG_GROUP_IDX: diag_byte = group_d;
            5'h08, 5'h09, 5'h0A, 5'h0B: diag_byte = chan_fault_q[8*req.byte_index[1:0] +: 8];
            5'h10, 5'h11, 5'h12, 5'h13: diag_byte = stamp_q[8*req.byte_index[1:0] +: 8];
            default: diag_byte = 8'h00;
        endcase
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            resp_q <= '0;
        end else if (clk_en) begin
            resp_q.valid <= req.rd;
            resp_q.error <= 1'b0;
            resp_q.data  <= 8'h00;
            if (req.rd) begin
                if (req.record_number == `REC_DIAG_SHORT && req.byte_index < `DIAG_SHORT_LEN) begin
                    resp_q.data <= diag_byte;
                end else if (req.record_number == `REC_DIAG_FULL && req.byte_index < `DIAG_FULL_LEN) begin
                    resp_q.data <= diag_byte;
                end else if (req.record_number >= `REC_RANGE_CH0 && req.record_number <= `REC_RANGE_CH3
                             && req.byte_index == 5'h00) begin
                    resp_q.data <= range_sel_q[8*req.record_number[1:0] +: 8];
                end else begin
                    resp_q.error <= 1'b1;
                end
            end
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    chk_range_reset: assert property ($rose(!sys_rst) |-> chan_active_q == 4'h0 ##0 range_sel_q == {4{8'h10}})
        else $error("range select not at reset value");
    chk_off_silent: assert property (clk_en && range_sel_q[7:0] == 8'hFF |=> !chan_active_q[0] && dac_mv_q[15:0] == 16'h0000)
        else $error("deactivated channel still drives");
    chk_short_mask: assert property (short_en_q[7:4] == 4'h0)
        else $error("reserved enable bits set");
    chk_s7_clamp: assert property (clk_en && range_sel_q[7:0] == 8'h10 |=> dac_mv_q[15:0] <= 16'd11759)
        else $error("format A range exceeds overrange");
    chk_s5_clamp: assert property (clk_en && range_sel_q[7:0] == 8'h20 && ao_codes[15] |=> dac_mv_q[15:0] == 16'h0000)
        else $error("negative code not clamped");
    chk_short_gate: assert property (!short_en_q[0] |-> !chan_fault_d[3])
        else $error("short reported while disabled");
    chk_led_follow: assert property (clk_en && group_d[3] |=> chan_err_led_q[3])
        else $error("channel indicator not lit");
    chk_read_latency: assert property (clk_en && req.rd |=> resp_q.valid)
        else $error("read answer missing");
    chk_param_err: assert property (clk_en && param_err[1] |=> summary_q[7] && chan_fault_q[8])
        else $error("parameter error not flagged");
    chk_ticker_step: assert property (clk_en && tick_div_q == 7'd124 |=> us_ticker_q == $past(us_ticker_q) + 32'h1)
        else $error("ticker did not advance");
    chk_class_byte: assert property (clk_en && req.rd && req.record_number == 8'h01 && req.byte_index == 5'h01
                                     |=> resp_q.data == 8'h15)
        else $error("module class byte wrong");

    cov_short_fault: cover property (clk_en && chan_fault_q[3]);
    cov_full_read: cover property (clk_en && req.rd && req.record_number == 8'h01 && req.byte_index == 5'h13);
    cov_bad_range: cover property (clk_en && summary_q[7]);

endmodule

`default_nettype wire
